//--- inc/add_bus_pkg.sv
package add_bus_pkg;
    localparam int unsigned ADR_W = 16;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned SEL_W = 4;
    // Register byte addresses
    localparam logic [15:0] LINE_DRIVE_ADDR = 16'h1F80;
    localparam logic [15:0] CTRL_ADDR = 16'h1F84;
    localparam logic [15:0] STATUS_ADDR = 16'h1F88;
    // Line drive register
    localparam int unsigned DRIVE_W = 8;
    localparam logic [7:0] DRIVE_RESET = 8'h00;
    localparam int unsigned GPO_A_BIT = 1;
    localparam int unsigned GPO_B_BIT = 5;
    // Control register
    localparam int unsigned CTRL_W = 9;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam int unsigned CH0_BUS_EN_BIT = 0;
    localparam int unsigned CH_FIELD_BASE = 1;
    localparam int unsigned CH_FIELD_W = 4;
    localparam int unsigned BUS_EN_OFS = 0;
    localparam int unsigned FRAMER_EN_OFS = 1;
    localparam int unsigned DUAL_RAIL_OFS = 2;
    localparam int unsigned INGRESS_OFS = 3;
    // Status register
    localparam int unsigned SLOTS = 3;
    localparam int unsigned OVERFLOW_BIT = 6;
    localparam int unsigned STATUS_W = 7;
    // Shared alarm pins (channels 2 and 3)
    localparam int unsigned NCH = 2;
    // Channel 0 add data path
    localparam int unsigned SAMPLE_W = 2;
    localparam int unsigned FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } busState_t;

    typedef enum logic [3:0] {
        SEL_NONE = 4'b0001,
        SEL_DRIVE = 4'b0010,
        SEL_CTRL = 4'b0100,
        SEL_STATUS = 4'b1000
    } regSel_t;
endpackage

//--- src/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic next_outValid;
    logic [WIDTH-1:0] next_outData;
    logic push, pop;

    always_comb begin
        // Output stage is one word ahead of the array
        push = inValid && (count < (AW+1)'(DEPTH));
        pop = (count != '0) && (!outValid || outReady);
        next_wrPtr = push ? ((wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1) : wrPtr;
        next_rdPtr = pop ? ((rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1) : rdPtr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_outValid = pop ? 1'b1 : (outReady ? 1'b0 : outValid);
        next_outData = pop ? mem[rdPtr] : outData;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            outValid <= 1'b0;
            outData <= '0;
            inReady <= 1'b0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            outValid <= next_outValid;
            outData <= next_outData;
            inReady <= (next_count < (AW+1)'(DEPTH));
        end
    end

    // Array has no reset; only read after a write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule // sample_fifo

//--- src/add_bus_pin_sharing.sv
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Each shared alarm pin acts as the path alarm input only while its channel's add bus is enabled.
// RULE2: Upstream logic pulses the alarm pin high in the same slot as an STS-1 carrying AIS-P.
// RULE3: An alarm seen in a slot declares AIS-P for that STS-1 with no software involvement.
// RULE4: With the add bus off and the framer on, the pin feeds the framer as LCV or negative rail.
// RULE5: Single-rail with ingress framing treats the pin as the line code violation input.
// RULE6: Dual-rail with ingress framing treats the pin as the negative rail data input.
// RULE7: The line input is ignored whenever framing is not placed in the ingress path.
// RULE8: With channel 0's add bus on, data bits are latched at the falling edge of its clock.
// RULE9: Data bit 0 carries the least significant bit of each transferred byte.
// RULE10: With channel 0's add bus off, data bit 0 is an output following drive register bit 1.
// RULE11: With channel 0's add bus off, data bit 1 is an output following drive register bit 5.
// RULE12: A repurposed pin never feeds add-bus data or alarm processing.
module add_bus_pin_sharing (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [add_bus_pkg::ADR_W-1:0] adr_i,
    input wire logic [add_bus_pkg::SEL_W-1:0] sel_i,
    input wire logic [add_bus_pkg::DAT_W-1:0] dat_i,
    output logic [add_bus_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic pathAlarmInCh2,
    input wire logic pathAlarmInCh3,
    input wire logic addBusClockCh0,
    input wire logic addBusDataBit0In,
    output logic addBusDataBit0Out,
    output logic addBusDataBit0Oe,
    input wire logic addBusDataBit1In,
    output logic addBusDataBit1Out,
    output logic addBusDataBit1Oe,
    output logic lineCodeViolationInCh2,
    output logic lineCodeViolationInCh3,
    output logic negativeRailInCh2,
    output logic negativeRailInCh3,
    output logic [add_bus_pkg::SLOTS-1:0] aisDeclaredCh2,
    output logic [add_bus_pkg::SLOTS-1:0] aisDeclaredCh3,
    output logic addDataValid,
    input wire logic addDataReady,
    output logic [add_bus_pkg::SAMPLE_W-1:0] addData
);
    import add_bus_pkg::*;

    function automatic regSel_t decodeAddr(input logic [ADR_W-1:0] a);
        if (a == LINE_DRIVE_ADDR) begin
            return SEL_DRIVE;
        end else if (a == CTRL_ADDR) begin
            return SEL_CTRL;
        end else if (a == STATUS_ADDR) begin
            return SEL_STATUS;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // Register bus
    busState_t busState, next_busState;
    logic [DRIVE_W-1:0] lineDriveControlCh0, next_lineDriveControlCh0;
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic overflow, next_overflow;
    logic [DAT_W-1:0] next_dat_o;
    logic next_ack_o;
    regSel_t sel;
    logic wrStrobe;

    // Channel 0 add data path
    logic prevClk, next_prevClk;
    logic sampleValid, next_sampleValid;
    logic [SAMPLE_W-1:0] sampleData, next_sampleData;
    logic ch0BusEn;
    logic fifoInReady;
    logic next_bit0Out, next_bit0Oe, next_bit1Out, next_bit1Oe;

    // Shared alarm pins
    logic [NCH-1:0] alarmPin;
    logic [NCH-1:0] lcv, neg;
    logic [SLOTS-1:0] ais [NCH];

    assign alarmPin = {pathAlarmInCh3, pathAlarmInCh2};
    assign ch0BusEn = ctrl[CH0_BUS_EN_BIT];

    always_comb begin
        sel = decodeAddr(adr_i);
        wrStrobe = (busState == BUS_IDLE) && cyc_i && stb_i && we_i;
        next_busState = busState;
        next_ack_o = 1'b0;
        next_dat_o = '0;
        next_lineDriveControlCh0 = lineDriveControlCh0;
        next_ctrl = ctrl;
        next_overflow = overflow;
        case (busState)
            BUS_IDLE: begin
                if (cyc_i && stb_i) begin
                    next_busState = BUS_ACK;
                    next_ack_o = 1'b1;
                    if (sel == SEL_DRIVE) begin
                        next_dat_o = DAT_W'(lineDriveControlCh0);
                    end else if (sel == SEL_CTRL) begin
                        next_dat_o = DAT_W'(ctrl);
                    end else if (sel == SEL_STATUS) begin
                        next_dat_o = DAT_W'({overflow, ais[1], ais[0]});
                    end
                end
            end
            BUS_ACK: begin
                // Ack lasts one cycle; the master drops its strobe next
                next_busState = BUS_IDLE;
            end
            default: begin
                next_busState = BUS_IDLE;
            end
        endcase
        if (wrStrobe && sel == SEL_DRIVE && sel_i[0]) begin
            next_lineDriveControlCh0 = dat_i[DRIVE_W-1:0];
        end
        if (wrStrobe && sel == SEL_CTRL) begin
            if (sel_i[0]) begin
                next_ctrl[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
                next_ctrl[CTRL_W-1:8] = dat_i[CTRL_W-1:8];
            end
        end
        if (wrStrobe && sel == SEL_STATUS && sel_i[0] && dat_i[OVERFLOW_BIT]) begin
            next_overflow = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (sampleValid && !fifoInReady) begin
            next_overflow = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busState <= BUS_IDLE;
            ack_o <= 1'b0;
            dat_o <= '0;
            lineDriveControlCh0 <= DRIVE_RESET;
            ctrl <= CTRL_RESET;
            overflow <= 1'b0;
        end else begin
            busState <= next_busState;
            ack_o <= next_ack_o;
            dat_o <= next_dat_o;
            lineDriveControlCh0 <= next_lineDriveControlCh0;
            ctrl <= next_ctrl;
            overflow <= next_overflow;
        end
    end

    always_comb begin
        next_prevClk = addBusClockCh0;
        next_sampleValid = 1'b0;
        next_sampleData = sampleData;
        // Falling edge seen as high then low on clk_sys samples
        if (ch0BusEn && prevClk && !addBusClockCh0) begin // see RULE8
            next_sampleValid = 1'b1;
            next_sampleData = {addBusDataBit1In, addBusDataBit0In}; // see RULE9
        end
        // Pins turn round only when the enable changes
        next_bit0Oe = !ch0BusEn; // see RULE12
        next_bit1Oe = !ch0BusEn; // see RULE12
        next_bit0Out = !ch0BusEn && lineDriveControlCh0[GPO_A_BIT]; // see RULE10
        next_bit1Out = !ch0BusEn && lineDriveControlCh0[GPO_B_BIT]; // see RULE11
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prevClk <= 1'b0;
            sampleValid <= 1'b0;
            sampleData <= '0;
            addBusDataBit0Out <= 1'b0;
            addBusDataBit0Oe <= 1'b0;
            addBusDataBit1Out <= 1'b0;
            addBusDataBit1Oe <= 1'b0;
        end else begin
            prevClk <= next_prevClk;
            sampleValid <= next_sampleValid;
            sampleData <= next_sampleData;
            addBusDataBit0Out <= next_bit0Out;
            addBusDataBit0Oe <= next_bit0Oe;
            addBusDataBit1Out <= next_bit1Out;
            addBusDataBit1Oe <= next_bit1Oe;
        end
    end

    // Pin source cannot stall; a full buffer drops the sample and flags it
    sample_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inValid(sampleValid),
        .inReady(fifoInReady),
        .inData(sampleData),
        .outValid(addDataValid),
        .outReady(addDataReady),
        .outData(addData)
    );

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic busEn, framerEn, dualRail, ingress;
        logic [1:0] slot, next_slot;
        logic [SLOTS-1:0] next_ais;
        logic next_lcv, next_neg;

        always_comb begin
            busEn = ctrl[CH_FIELD_BASE + i*CH_FIELD_W + BUS_EN_OFS];
            framerEn = ctrl[CH_FIELD_BASE + i*CH_FIELD_W + FRAMER_EN_OFS];
            dualRail = ctrl[CH_FIELD_BASE + i*CH_FIELD_W + DUAL_RAIL_OFS];
            ingress = ctrl[CH_FIELD_BASE + i*CH_FIELD_W + INGRESS_OFS];
            next_slot = '0;
            next_ais = '0; // see RULE12
            if (busEn) begin // see RULE1
                // One STS-1 slot per clk_sys cycle, three per STS-3 round
                next_slot = (slot == 2'(SLOTS-1)) ? '0 : slot + 1'b1;
                next_ais = ais[i];
                next_ais[slot] = alarmPin[i]; // see RULE3
            end
            // Framing outside the ingress path leaves the pin unused
            next_lcv = !busEn && framerEn && ingress && !dualRail && alarmPin[i]; // see RULE4
            next_neg = !busEn && framerEn && ingress && dualRail && alarmPin[i]; // see RULE6
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                slot <= '0;
                ais[i] <= '0;
                lcv[i] <= 1'b0;
                neg[i] <= 1'b0;
            end else begin
                slot <= next_slot;
                ais[i] <= next_ais;
                lcv[i] <= next_lcv; // see RULE5
                neg[i] <= next_neg; // see RULE7
            end
        end
    end

    assign lineCodeViolationInCh2 = lcv[0];
    assign lineCodeViolationInCh3 = lcv[1];
    assign negativeRailInCh2 = neg[0];
    assign negativeRailInCh3 = neg[1];
    assign aisDeclaredCh2 = ais[0];
    assign aisDeclaredCh3 = ais[1];
endmodule // add_bus_pin_sharing

//--- verif/add_bus_pin_sharing_chk.sv
`timescale 1ns/1ps
module add_bus_pin_sharing_chk (
    input logic clk_sys,
    input logic rst_n,
    input logic cyc_i,
    input logic stb_i,
    input logic we_i,
    input logic [add_bus_pkg::ADR_W-1:0] adr_i,
    input logic [add_bus_pkg::SEL_W-1:0] sel_i,
    input logic [add_bus_pkg::DAT_W-1:0] dat_i,
    input logic ack_o,
    input logic pathAlarmInCh2,
    input logic addBusDataBit0Out,
    input logic addBusDataBit0Oe,
    input logic addBusDataBit1Out,
    input logic addBusDataBit1Oe,
    input logic lineCodeViolationInCh2,
    input logic negativeRailInCh2,
    input logic [add_bus_pkg::SLOTS-1:0] aisDeclaredCh2,
    input logic addDataValid,
    input logic addDataReady,
    input logic [add_bus_pkg::SAMPLE_W-1:0] addData
);
    import add_bus_pkg::*;
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [DRIVE_W-1:0] drive;
    logic [DRIVE_W-1:0] next_drive;
    logic taken;
    logic lineOk;
    // Shadow registers from observed writes; a held request is not retaken
    assign taken = cyc_i && stb_i && we_i && !ack_o;
    assign lineOk = pathAlarmInCh2 && !ctrl[1] && ctrl[2] && ctrl[4];
    always_comb begin
        next_ctrl = ctrl;
        next_drive = drive;
        if (taken && sel_i[0] && adr_i == LINE_DRIVE_ADDR) next_drive = dat_i[7:0];
        if (taken && sel_i[1:0] == 2'b11 && adr_i == CTRL_ADDR) next_ctrl = dat_i[8:0];
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            drive <= DRIVE_RESET;
        end else begin
            ctrl <= next_ctrl;
            drive <= next_drive;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_gpo_a_level: assert property (
        addBusDataBit0Oe && $stable(drive) |-> addBusDataBit0Out == drive[GPO_A_BIT])
        else $error("general output a level wrong");
    a_gpo_b_level: assert property (
        addBusDataBit1Oe && $stable(drive) |-> addBusDataBit1Out == drive[GPO_B_BIT])
        else $error("general output b level wrong");
    a_oe_follows_en: assert property ($past(rst_n) |-> addBusDataBit0Oe != $past(ctrl[0])
        && addBusDataBit1Oe == addBusDataBit0Oe) else $error("pin enable wrong");
    a_line_code: assert property (
        $past(rst_n) |-> lineCodeViolationInCh2 == $past(lineOk && !ctrl[3]))
        else $error("line code output wrong");
    a_neg_rail: assert property (
        $past(rst_n) |-> negativeRailInCh2 == $past(lineOk && ctrl[3]))
        else $error("negative rail output wrong");
    a_ais_declare: assert property (pathAlarmInCh2 && ctrl[1] |=> aisDeclaredCh2 != 3'h0)
        else $error("alarm not declared");
    a_ais_off: assert property (
        $past(rst_n) && !$past(ctrl[1]) |-> aisDeclaredCh2 == 3'h0)
        else $error("alarm declared while bus off");
    a_no_capture: assert property ((!ctrl[0] && !addDataValid) [*5] |=> !addDataValid)
        else $error("sample taken while bus off");
    a_data_holds: assert property (
        addDataValid && !addDataReady |=> addDataValid && $stable(addData))
        else $error("sample changed while stalled");
    c_ais_all: cover property (aisDeclaredCh2 == 3'h7);
    c_stall: cover property (addDataValid && !addDataReady);
    c_gpo_high: cover property (addBusDataBit0Oe && addBusDataBit1Out);
endmodule // add_bus_pin_sharing_chk
bind add_bus_pin_sharing add_bus_pin_sharing_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .pathAlarmInCh2(pathAlarmInCh2), .addBusDataBit0Out(addBusDataBit0Out),
    .addBusDataBit0Oe(addBusDataBit0Oe), .addBusDataBit1Out(addBusDataBit1Out),
    .addBusDataBit1Oe(addBusDataBit1Oe), .lineCodeViolationInCh2(lineCodeViolationInCh2),
    .negativeRailInCh2(negativeRailInCh2), .aisDeclaredCh2(aisDeclaredCh2),
    .addDataValid(addDataValid), .addDataReady(addDataReady), .addData(addData));

//--- verif/add_bus_source.sv
`timescale 1ns/1ps
module add_bus_source (
    input wire logic clk_sys,
    output logic addClk,
    output logic [1:0] addPins,
    output logic alarm2,
    output logic alarm3
);
    initial begin
        addClk = 1'b0;
        addPins = 2'b00;
        alarm2 = 1'b0;
        alarm3 = 1'b0;
    end
    // Byte bit 0 on pin 0, held across the falling edge
    task automatic sendSample(input logic [1:0] v, input int gap);
        addPins <= v;
        addClk <= 1'b1;
        repeat (gap) @(posedge clk_sys);
        addClk <= 1'b0;
        repeat (gap) @(posedge clk_sys);
        // Stale data inverted, so nothing can pass on a leftover value
        addPins <= ~v;
        @(posedge clk_sys);
    endtask
    // Alarm level lines up with the slots it flags
    task automatic holdAlarm(input logic lvl, input int n);
        alarm2 <= lvl;
        alarm3 <= lvl;
        repeat (n) @(posedge clk_sys);
    endtask
endmodule // add_bus_source

//--- verif/add_bus_pin_sharing_tb.sv
`timescale 1ns/1ps
module add_bus_pin_sharing_tb;
    import add_bus_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic ready = 1'b0;
    logic [15:0] adr = 16'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat;
    logic ack, gpoA, oeA, gpoB, oeB, lcv2, lcv3, neg2, neg3, valid, sClk, al2, al3;
    logic [2:0] ais2, ais3;
    logic [1:0] sPins, data;
    logic [7:0] drv [4] = '{8'h02, 8'h20, 8'hDD, 8'h22};
    logic [3:0] modes [5] = '{4'hA, 4'hE, 4'h6, 4'h8, 4'hB};
    int miscompares = 0;
    int samplesChecked = 0;
    wire pin0 = oeA ? gpoA : sPins[0];
    wire pin1 = oeB ? gpoB : sPins[1];
    always #2 clk_sys = ~clk_sys;
    add_bus_pin_sharing dut (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_i(req), .stb_i(req),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat), .ack_o(ack),
        .pathAlarmInCh2(al2), .pathAlarmInCh3(al3), .addBusClockCh0(sClk),
        .addBusDataBit0In(pin0), .addBusDataBit0Out(gpoA), .addBusDataBit0Oe(oeA),
        .addBusDataBit1In(pin1), .addBusDataBit1Out(gpoB), .addBusDataBit1Oe(oeB),
        .lineCodeViolationInCh2(lcv2), .lineCodeViolationInCh3(lcv3),
        .negativeRailInCh2(neg2), .negativeRailInCh3(neg3), .aisDeclaredCh2(ais2),
        .aisDeclaredCh3(ais3), .addDataValid(valid), .addDataReady(ready), .addData(data));
    add_bus_source src (.clk_sys(clk_sys), .addClk(sClk), .addPins(sPins), .alarm2(al2),
        .alarm3(al3));
    function automatic logic [4:0] route(input logic [3:0] m);
        return {m == 4'hA, m == 4'hE, {3{m[0]}}};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            conclude();
        end
        rdat = dat;
        req <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        check(rdat, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
    initial begin
        int n;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(LINE_DRIVE_ADDR, 32'h0);
        rd(CTRL_ADDR, 32'h0);
        check({oeB, gpoB, oeA, gpoA}, 4'hA);
        foreach (drv[i]) begin
            wb(LINE_DRIVE_ADDR, 1'b1, {24'h0, drv[i]});
            check({gpoB, gpoA}, {drv[i][GPO_B_BIT], drv[i][GPO_A_BIT]});
        end
        rd(LINE_DRIVE_ADDR, 32'h22);
        wb(16'h1F8C, 1'b1, 32'hFF);
        rd(16'h1F8C, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wb(CTRL_ADDR, 1'b1, {23'h0, modes[(i + 1) % 5], modes[i], 1'b0});
            src.holdAlarm(1'b1, 4);
            check({lcv3, neg3, ais3, lcv2, neg2, ais2},
                {route(modes[(i + 1) % 5]), route(modes[i])});
        end
        rd(STATUS_ADDR, 32'h7);
        src.holdAlarm(1'b0, 4);
        check(ais2, 3'h0);
        wb(CTRL_ADDR, 1'b1, 32'h1);
        check({oeB, oeA}, 2'b00);
        for (int i = 0; i < 10; i++) src.sendSample(i[1:0], 1 + i % 2);
        rd(STATUS_ADDR, 32'h40);
        ready <= 1'b1;
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (valid !== 1'b1 && n < 20);
            if (n >= 20) begin
                miscompares++;
                conclude();
            end
            check(data, i[1:0]);
        end
        repeat (4) @(posedge clk_sys);
        check(valid, 1'b0);
        wb(STATUS_ADDR, 1'b1, 32'h40);
        rd(STATUS_ADDR, 32'h0);
        wb(CTRL_ADDR, 1'b1, 32'h0);
        src.sendSample(2'b11, 2);
        repeat (5) @(posedge clk_sys);
        check({valid, oeB, oeA}, 3'b011);
        conclude();
    end
endmodule // add_bus_pin_sharing_tb
